// ===== hdl/cie_pkg.sv
// Constants for the interrupt entry and exit block
package cie_pkg;
  localparam int DW = 8;
  localparam int PCW = 15;
  localparam int NPER = 24;
  localparam int STK_DEPTH = 16;
  localparam int SPW = 5;
  localparam logic [PCW-1:0] VECTOR_ADDR = 15'h0004;
  // Control register fields
  localparam int CTL_GIE = 7;
  localparam int CTL_PERIPHERAL_IRQ_GATE = 6;
  localparam int CTL_TMR_IE = 5;
  localparam int CTL_EXT_IE = 4;
  localparam int CTL_IOC_IE = 3;
  localparam int CTL_TMR_IF = 2;
  localparam int CTL_EXT_IF = 1;
  localparam int CTL_IOC_IF = 0;
  localparam logic [DW-1:0] CTL_RESET = 8'h00;
  localparam logic [DW-1:0] STATUS_KEEP = 8'he7;
  // Register port offsets
  localparam logic [3:0] A_CTL = 4'h0;
  localparam logic [3:0] A_PIR_A = 4'h1;
  localparam logic [3:0] A_PIR_B = 4'h2;
  localparam logic [3:0] A_PIR_C = 4'h3;
  localparam logic [3:0] A_PIE_A = 4'h4;
  localparam logic [3:0] A_PIE_B = 4'h5;
  localparam logic [3:0] A_PIE_C = 4'h6;
  localparam logic [3:0] A_SP = 4'h7;
  // Sequencer: entry takes fixed cycles so latency lands at 3 to 4
  typedef enum logic [3:0] {
    CIE_RUN = 4'b0001,
    CIE_FLUSH = 4'b0010,
    CIE_PUSH = 4'b0100,
    CIE_VEC = 4'b1000
  } cie_state_e;
endpackage : cie_pkg

// ===== hdl/cie_stack.sv
// Hardware return stack with overflow and underflow detection
`timescale 1ns/1ps
module cie_stack import cie_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic push,
  input wire logic pop,
  input wire logic [PCW-1:0] push_data,
  output logic [PCW-1:0] top_q,
  output logic [SPW-1:0] sp_q,
  output logic ovf_q,
  output logic unf_q
);
  logic [PCW-1:0] mem [STK_DEPTH];
  logic [SPW-1:0] sp_d;
  logic ovf_d, unf_d;
  logic [PCW-1:0] top_d;

  always_comb begin
    sp_d = sp_q;
    ovf_d = 1'b0;
    unf_d = 1'b0;
    top_d = top_q;
    // Top kept current so a return needs no extra read cycle
    if (push) begin
      if (sp_q == SPW'(STK_DEPTH)) ovf_d = 1'b1;
      else begin
        sp_d = sp_q + 5'h01;
        top_d = push_data;
      end
    end else if (pop) begin
      if (sp_q == 5'h00) unf_d = 1'b1;
      else begin
        sp_d = sp_q - 5'h01;
        top_d = (sp_q == 5'h01) ? '0 : mem[sp_q[3:0] - 4'h2];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push && sp_q != SPW'(STK_DEPTH)) mem[sp_q[3:0]] <= push_data;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sp_q <= 5'h00;
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
      top_q <= '0;
    end else begin
      sp_q <= sp_d;
      ovf_q <= ovf_d;
      unf_q <= unf_d;
      top_q <= top_d;
    end
  end
endmodule : cie_stack

// ===== hdl/cie_irq_ctrl.sv
// Interrupt entry and exit control for a small 8-bit core
`timescale 1ns/1ps
module cie_irq_ctrl import cie_pkg::*; (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Core pipeline
  input wire logic INSTR_BOUNDARY,
  input wire logic RETURN_FROM_IRQ_INSTR,
  input wire logic CALL_PUSH,
  input wire logic RET_POP,
  input wire logic [PCW-1:0] PC_NOW,
  input wire logic WAKE_EVENT,
  input wire logic AFTER_SLEEP_DONE,
  // Context to shadow
  input wire logic [DW-1:0] W_NOW,
  input wire logic [DW-1:0] STATUS_NOW,
  input wire logic [DW-1:0] BANK_SELECT_REG_NOW,
  input wire logic [15:0] FILE_SELECT_REG0_NOW,
  input wire logic [15:0] FILE_SELECT_REG1_NOW,
  input wire logic [6:0] PC_HIGH_LATCH_NOW,
  // Event sources
  input wire logic TMR_EVENT,
  input wire logic IOC_EVENT,
  input wire logic EXT_PIN,
  input wire logic EXT_EDGE_SELECT,
  input wire logic [NPER-1:0] PERIPH_EVENT,
  // Register port
  input wire logic [3:0] ADDR,
  input wire logic [DW-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [DW-1:0] RDATA,
  // Pipeline control out
  output logic FLUSH,
  output logic LOAD_PC,
  output logic [PCW-1:0] PC_LOAD_VALUE,
  output logic RESTORE,
  output logic STACK_OVERFLOW,
  output logic STACK_UNDERFLOW,
  output logic IRQ_PENDING,
  // Shadow copies
  output logic [DW-1:0] W_SHADOW,
  output logic [DW-1:0] STATUS_SHADOW,
  output logic [DW-1:0] BANK_SELECT_REG_SHADOW,
  output logic [15:0] FILE_SELECT_REG0_SHADOW,
  output logic [15:0] FILE_SELECT_REG1_SHADOW,
  output logic [6:0] PC_HIGH_LATCH_SHADOW
);
  logic [DW-1:0] ctl_q, ctl_d;
  logic [NPER-1:0] pir_q, pir_d, pie_q, pie_d;
  logic ext_prev_q;
  logic wake_hold_q, wake_hold_d;
  cie_state_e st_q, st_d;
  logic [DW-1:0] rdata_d;
  logic flush_d, load_d, restore_d;
  logic [PCW-1:0] pcv_d;
  logic any_req, take, ext_edge, stk_push, stk_pop;
  logic [PCW-1:0] stk_top;
  logic [SPW-1:0] stk_sp;
  logic stk_ovf, stk_unf;
  logic [NPER-1:0] per_set;
  logic [NPER-1:0] per_hit;

  // Per-source request terms
  genvar gi;
  generate
    for (gi = 0; gi < NPER; gi++) begin : g_per
      assign per_set[gi] = PERIPH_EVENT[gi];
      assign per_hit[gi] = pir_q[gi] & pie_q[gi];
    end
  endgenerate

  // Edge picked by the select bit
  assign ext_edge = EXT_EDGE_SELECT ? (EXT_PIN & ~ext_prev_q)
                                    : (~EXT_PIN & ext_prev_q);

  // Combined request
  assign any_req = (ctl_q[CTL_TMR_IF] & ctl_q[CTL_TMR_IE])
                 | (ctl_q[CTL_EXT_IF] & ctl_q[CTL_EXT_IE])
                 | (ctl_q[CTL_IOC_IF] & ctl_q[CTL_IOC_IE])
                 | (ctl_q[CTL_PERIPHERAL_IRQ_GATE] & |per_hit);
  // Held while the post-sleep instruction runs
  assign take = st_q == CIE_RUN && INSTR_BOUNDARY && ctl_q[CTL_GIE] && any_req
              && !wake_hold_q && !RETURN_FROM_IRQ_INSTR;

  // Shared stack
  assign stk_push = CALL_PUSH | (st_q == CIE_PUSH);
  assign stk_pop = RET_POP | RETURN_FROM_IRQ_INSTR;

  cie_stack u_stack (
    .clk(MCLK),
    .rst(RST),
    .push(stk_push),
    .pop(stk_pop),
    .push_data(PC_NOW),
    .top_q(stk_top),
    .sp_q(stk_sp),
    .ovf_q(stk_ovf),
    .unf_q(stk_unf)
  );

  // Registers and flags
  always_comb begin
    ctl_d = ctl_q;
    pir_d = pir_q;
    pie_d = pie_q;
    rdata_d = '0;
    if (WR) begin
      case (ADDR)
        A_CTL: ctl_d = WDATA;
        A_PIR_A: pir_d[7:0] = WDATA;
        A_PIR_B: pir_d[15:8] = WDATA;
        A_PIR_C: pir_d[23:16] = WDATA;
        A_PIE_A: pie_d[7:0] = WDATA;
        A_PIE_B: pie_d[15:8] = WDATA;
        A_PIE_C: pie_d[23:16] = WDATA;
        default: ;
      endcase
    end
    // Set wins over a software clear in the same cycle
    if (TMR_EVENT) ctl_d[CTL_TMR_IF] = 1'b1;
    if (IOC_EVENT) ctl_d[CTL_IOC_IF] = 1'b1;
    if (ext_edge) ctl_d[CTL_EXT_IF] = 1'b1;
    pir_d = pir_d | per_set;
    if (take) ctl_d[CTL_GIE] = 1'b0;
    if (RETURN_FROM_IRQ_INSTR) ctl_d[CTL_GIE] = 1'b1;
    if (RD) begin
      case (ADDR)
        A_CTL: rdata_d = ctl_q;
        A_PIR_A: rdata_d = pir_q[7:0];
        A_PIR_B: rdata_d = pir_q[15:8];
        A_PIR_C: rdata_d = pir_q[23:16];
        A_PIE_A: rdata_d = pie_q[7:0];
        A_PIE_B: rdata_d = pie_q[15:8];
        A_PIE_C: rdata_d = pie_q[23:16];
        A_SP: rdata_d = {3'h0, stk_sp};
        default: rdata_d = '0;
      endcase
    end
  end

  // Entry sequencer
  always_comb begin
    st_d = st_q;
    flush_d = 1'b0;
    load_d = 1'b0;
    restore_d = 1'b0;
    pcv_d = PC_LOAD_VALUE;
    wake_hold_d = wake_hold_q;
    if (WAKE_EVENT) wake_hold_d = 1'b1;
    else if (AFTER_SLEEP_DONE) wake_hold_d = 1'b0;
    case (st_q)
      CIE_RUN: begin
        if (take) begin
          st_d = CIE_FLUSH;
          flush_d = 1'b1;
        end else if (RETURN_FROM_IRQ_INSTR) begin
          load_d = 1'b1;
          restore_d = 1'b1;
          pcv_d = stk_top;
        end
      end
      CIE_FLUSH: st_d = CIE_PUSH;
      CIE_PUSH: st_d = CIE_VEC;
      CIE_VEC: begin
        st_d = CIE_RUN;
        load_d = 1'b1;
        pcv_d = VECTOR_ADDR;
      end
      default: st_d = CIE_RUN;
    endcase
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ctl_q <= CTL_RESET;
      pir_q <= '0;
      pie_q <= '0;
      ext_prev_q <= 1'b0;
      wake_hold_q <= 1'b0;
      st_q <= CIE_RUN;
      RDATA <= '0;
      FLUSH <= 1'b0;
      LOAD_PC <= 1'b0;
      PC_LOAD_VALUE <= '0;
      RESTORE <= 1'b0;
      STACK_OVERFLOW <= 1'b0;
      STACK_UNDERFLOW <= 1'b0;
      IRQ_PENDING <= 1'b0;
      W_SHADOW <= '0;
      STATUS_SHADOW <= '0;
      BANK_SELECT_REG_SHADOW <= '0;
      FILE_SELECT_REG0_SHADOW <= '0;
      FILE_SELECT_REG1_SHADOW <= '0;
      PC_HIGH_LATCH_SHADOW <= '0;
    end else begin
      ctl_q <= ctl_d;
      pir_q <= pir_d;
      pie_q <= pie_d;
      ext_prev_q <= EXT_PIN;
      wake_hold_q <= wake_hold_d;
      st_q <= st_d;
      RDATA <= rdata_d;
      FLUSH <= flush_d;
      LOAD_PC <= load_d;
      PC_LOAD_VALUE <= pcv_d;
      RESTORE <= restore_d;
      STACK_OVERFLOW <= stk_ovf;
      STACK_UNDERFLOW <= stk_unf;
      IRQ_PENDING <= any_req;
      if (take) begin
        W_SHADOW <= W_NOW;
        STATUS_SHADOW <= STATUS_NOW & STATUS_KEEP;
        BANK_SELECT_REG_SHADOW <= BANK_SELECT_REG_NOW;
        FILE_SELECT_REG0_SHADOW <= FILE_SELECT_REG0_NOW;
        FILE_SELECT_REG1_SHADOW <= FILE_SELECT_REG1_NOW;
        PC_HIGH_LATCH_SHADOW <= PC_HIGH_LATCH_NOW;
      end
    end
  end

  // Checks
  property p_reset_gie;
    @(posedge MCLK) $fell(RST) |-> !ctl_q[CTL_GIE];
  endproperty
  a_reset_gie: assert property (p_reset_gie) else $error("global enable set after reset");

  property p_gated;
    @(posedge MCLK) disable iff (RST)
      FLUSH |-> $past(ctl_q[CTL_GIE]) && $past(
        ctl_q[CTL_TMR_IF] && ctl_q[CTL_TMR_IE] || ctl_q[CTL_EXT_IF] && ctl_q[CTL_EXT_IE]
        || ctl_q[CTL_IOC_IF] && ctl_q[CTL_IOC_IE] || ctl_q[CTL_PERIPHERAL_IRQ_GATE] && |(pir_q & pie_q));
  endproperty
  a_gated: assert property (p_gated) else $error("entry without enables");

  property p_flag_set;
    @(posedge MCLK) disable iff (RST) TMR_EVENT |=> ctl_q[CTL_TMR_IF];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event flag not set");

  property p_entry;
    @(posedge MCLK) disable iff (RST)
      take |=> FLUSH && !ctl_q[CTL_GIE] ##3 LOAD_PC && PC_LOAD_VALUE == VECTOR_ADDR;
  endproperty
  a_entry: assert property (p_entry) else $error("entry sequence wrong");

  property p_no_nest;
    @(posedge MCLK) disable iff (RST) FLUSH |=> (!FLUSH) [*3];
  endproperty
  a_no_nest: assert property (p_no_nest) else $error("nested entry");

  property p_return;
    @(posedge MCLK) disable iff (RST)
      RETURN_FROM_IRQ_INSTR && st_q == CIE_RUN |=> ctl_q[CTL_GIE] && RESTORE && LOAD_PC;
  endproperty
  a_return: assert property (p_return) else $error("return did not restore");

  property p_wait;
    @(posedge MCLK) disable iff (RST) !ctl_q[CTL_GIE] |=> !FLUSH;
  endproperty
  a_wait: assert property (p_wait) else $error("vectored while disabled");

  property p_ext_edge;
    @(posedge MCLK) disable iff (RST)
      EXT_EDGE_SELECT && EXT_PIN && !ext_prev_q |=> ctl_q[CTL_EXT_IF];
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("pin edge missed");

  property p_wake;
    @(posedge MCLK) disable iff (RST) wake_hold_q |=> !FLUSH;
  endproperty
  a_wake: assert property (p_wake) else $error("vector before post-sleep instr");

  // Outputs checked, not the take term, so a broken W, status or PC high shadow flop still trips these
  property p_shadow;
    @(posedge MCLK) disable iff (RST)
      take |=> W_SHADOW == $past(W_NOW) && PC_HIGH_LATCH_SHADOW == $past(PC_HIGH_LATCH_NOW)
      && STATUS_SHADOW == ($past(STATUS_NOW) & STATUS_KEEP);
  endproperty
  a_shadow: assert property (p_shadow) else $error("context not shadowed");

  property p_boundary;
    @(posedge MCLK) disable iff (RST) FLUSH |-> $past(INSTR_BOUNDARY);
  endproperty
  a_boundary: assert property (p_boundary) else $error("entry off a boundary");

  property p_push;
    @(posedge MCLK) disable iff (RST)
      st_q == CIE_PUSH && stk_sp != SPW'(STK_DEPTH) |=> stk_sp == $past(stk_sp) + 5'h01;
  endproperty
  a_push: assert property (p_push) else $error("entry did not push");

  c_entry: cover property (@(posedge MCLK) disable iff (RST) take ##4 LOAD_PC);
  c_wake: cover property (@(posedge MCLK) disable iff (RST) wake_hold_q && any_req);
  c_return: cover property (@(posedge MCLK) disable iff (RST) RETURN_FROM_IRQ_INSTR);
  c_periph: cover property (@(posedge MCLK) disable iff (RST) take && |per_hit);
endmodule : cie_irq_ctrl

// ===== verification/cie_core_model.sv
// Core pipeline model: boundaries, program counter and context
`timescale 1ns/1ps
module cie_core_model import cie_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // From the block
  input wire logic flush,
  input wire logic load_pc,
  input wire logic [PCW-1:0] pc_load_value,
  // To the block
  output logic boundary,
  output logic [PCW-1:0] pc_now,
  output logic [PCW-1:0] ret_pc,
  output logic [DW-1:0] w_now,
  output logic [DW-1:0] status_now,
  output logic [15:0] fsr_now
);
  logic [1:0] cyc_q;
  // Four clocks per instruction; boundary on the last one
  assign boundary = (cyc_q == 2'h3);
  // Fixed context keeps shadow expectations exact
  assign w_now = 8'h3c;
  assign status_now = 8'hff;
  assign fsr_now = 16'h1234;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc_q <= 2'h0;
      pc_now <= 15'h0100;
      ret_pc <= 15'h0000;
    end else begin
      cyc_q <= cyc_q + 2'h1;
      // Push happens before the next boundary, so this is the return address
      if (flush) begin
        ret_pc <= pc_now;
      end
      if (load_pc) begin
        pc_now <= pc_load_value;
      end else if (boundary) begin
        pc_now <= pc_now + 15'h0001;
      end
    end
  end
endmodule : cie_core_model

// ===== verification/cie_irq_ctrl_tb.sv
// Self-checking bench for the interrupt entry and exit block
`timescale 1ns/1ps
module cie_irq_ctrl_tb import cie_pkg::*; ;
  logic mclk, rst, ext_pin, ext_sel, wr, rd, bnd, flush, load_pc, restore, ovf, unf, irq_pend;
  logic [6:0] evt;
  logic [6:0] pch_sh;
  logic [NPER-1:0] per_ev;
  logic [3:0] addr;
  logic [DW-1:0] wdata, rdata, w_now, st_now, w_sh, st_sh, bsr_sh;
  logic [15:0] fsr_now, fsr_sh, fsr1_sh;
  logic [PCW-1:0] pc_now, ret_pc, pc_ld, last_ld;
  int error_cnt, compares, flush_cnt, restore_cnt, ovf_cnt, unf_cnt;
  cie_core_model core (.clk(mclk), .rst(rst), .flush(flush), .load_pc(load_pc),
    .pc_load_value(pc_ld), .boundary(bnd), .pc_now(pc_now), .ret_pc(ret_pc),
    .w_now(w_now), .status_now(st_now), .fsr_now(fsr_now));
  cie_irq_ctrl dut (.MCLK(mclk), .RST(rst), .INSTR_BOUNDARY(bnd), .RETURN_FROM_IRQ_INSTR(evt[2]),
    .CALL_PUSH(evt[5]), .RET_POP(evt[6]), .PC_NOW(pc_now), .WAKE_EVENT(evt[3]),
    .AFTER_SLEEP_DONE(evt[4]), .W_NOW(w_now), .STATUS_NOW(st_now), .BANK_SELECT_REG_NOW(w_now),
    .FILE_SELECT_REG0_NOW(fsr_now), .FILE_SELECT_REG1_NOW(fsr_now),
    .PC_HIGH_LATCH_NOW(pc_now[14:8]), .TMR_EVENT(evt[0]), .IOC_EVENT(evt[1]), .EXT_PIN(ext_pin),
    .EXT_EDGE_SELECT(ext_sel), .PERIPH_EVENT(per_ev), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .FLUSH(flush), .LOAD_PC(load_pc), .PC_LOAD_VALUE(pc_ld),
    .RESTORE(restore), .STACK_OVERFLOW(ovf), .STACK_UNDERFLOW(unf), .IRQ_PENDING(irq_pend),
    .W_SHADOW(w_sh), .STATUS_SHADOW(st_sh), .BANK_SELECT_REG_SHADOW(bsr_sh),
    .FILE_SELECT_REG0_SHADOW(fsr_sh), .FILE_SELECT_REG1_SHADOW(fsr1_sh),
    .PC_HIGH_LATCH_SHADOW(pch_sh));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Pulse outputs last one cycle, so count them at every edge
  always @(posedge mclk) begin
    if (flush === 1'b1) flush_cnt++;
    if (restore === 1'b1) restore_cnt++;
    if (ovf === 1'b1) ovf_cnt++;
    if (unf === 1'b1) unf_cnt++;
    if (load_pc === 1'b1) last_ld = pc_ld;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk
  task idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle
  task wr_reg(input logic [3:0] a, input logic [DW-1:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_chk(input logic [3:0] a, input logic [DW-1:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(16'(rdata), 16'(exp), "register read");
  endtask : rd_chk
  task pulse(input int b);
    @(posedge mclk);
    evt[b] <= 1'b1;
    @(posedge mclk);
    evt[b] <= 1'b0;
  endtask : pulse
  // Bounded wait for one more entry, then the vector load
  task wait_entry(input int n);
    for (int i = 0; i < 20 && flush_cnt == n; i++) @(posedge mclk);
    idle(5);
    chk(16'(flush_cnt), 16'(n + 1), "entry count");
    chk(16'(last_ld), 16'(VECTOR_ADDR), "vector load");
  endtask : wait_entry
  task do_return(input int n);
    pulse(2);
    idle(2);
    chk(16'(last_ld), 16'(ret_pc), "return address");
    chk(16'(restore_cnt), 16'(n), "restore pulse");
  endtask : do_return
  task t_gated_entry;
    rd_chk(A_CTL, CTL_RESET);
    wr_reg(A_CTL, 8'h20);
    pulse(0);
    idle(12);
    chk(16'(flush_cnt), 16'h0, "no entry with global enable clear");
    chk(16'(irq_pend), 16'h1, "request pending while disabled");
    rd_chk(A_CTL, 8'h24);
    wr_reg(A_CTL, 8'ha4);
    wait_entry(0);
    rd_chk(A_CTL, 8'h24);
    chk(16'(st_sh), 16'(8'hff & STATUS_KEEP), "status shadow");
    chk(16'(w_sh), 16'h003c, "work shadow");
    chk(fsr_sh, 16'h1234, "file select shadow");
    chk(fsr1_sh, 16'h1234, "second file select shadow");
    chk(16'(bsr_sh), 16'h003c, "bank shadow");
    chk(16'(pch_sh), 16'(ret_pc[14:8]), "pc high shadow");
    $display("t_gated_entry done");
  endtask : t_gated_entry
  task t_isr_return;
    pulse(1);
    idle(12);
    chk(16'(flush_cnt), 16'h1, "no nested entry");
    rd_chk(A_CTL, 8'h25);
    wr_reg(A_CTL, 8'h20);
    do_return(1);
    rd_chk(A_CTL, 8'ha0);
    idle(12);
    chk(16'(flush_cnt), 16'h1, "no repeat after flags cleared");
    chk(16'(irq_pend), 16'h0, "no request after flags cleared");
    $display("t_isr_return done");
  endtask : t_isr_return
  task t_periph_gate;
    wr_reg(A_PIE_B, 8'h02);
    @(posedge mclk);
    per_ev[9] <= 1'b1;
    @(posedge mclk);
    per_ev[9] <= 1'b0;
    idle(12);
    chk(16'(flush_cnt), 16'h1, "gate closed blocks entry");
    rd_chk(A_PIR_B, 8'h02);
    wr_reg(A_CTL, 8'he0);
    wait_entry(1);
    wr_reg(A_PIR_B, 8'h00);
    do_return(2);
    rd_chk(A_CTL, 8'he0);
    wr_reg(A_CTL, 8'h00);
    $display("t_periph_gate done");
  endtask : t_periph_gate
  task t_stack;
    pulse(6);
    idle(3);
    chk(16'(unf_cnt), 16'h1, "pop of empty stack");
    repeat (16) pulse(5);
    rd_chk(A_SP, 8'h10);
    chk(16'(ovf_cnt), 16'h0, "no overflow at full depth");
    pulse(5);
    idle(3);
    chk(16'(ovf_cnt), 16'h1, "push onto full stack");
    repeat (16) pulse(6);
    rd_chk(A_SP, 8'h00);
    chk(16'(unf_cnt), 16'h1, "no underflow while emptying");
    $display("t_stack done");
  endtask : t_stack
  task t_ext_edge;
    @(posedge mclk);
    ext_sel <= 1'b1;
    ext_pin <= 1'b1;
    idle(4);
    rd_chk(A_CTL, 8'h02);
    wr_reg(A_CTL, 8'h00);
    ext_pin <= 1'b0;
    idle(4);
    ext_sel <= 1'b0;
    ext_pin <= 1'b1;
    idle(4);
    rd_chk(A_CTL, 8'h00);
    wr_reg(A_CTL, 8'h90);
    pulse(3);
    ext_pin <= 1'b0;
    idle(14);
    rd_chk(A_CTL, 8'h92);
    chk(16'(flush_cnt), 16'h2, "held while waking");
    pulse(4);
    wait_entry(2);
    $display("t_ext_edge done");
  endtask : t_ext_edge
  task complete_run;
    $display("Comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  // Tests need well under a thousand cycles
  initial begin
    #20000;
    error_cnt++;
    complete_run();
  end
  initial begin
    rst = 1'b1;
    {ext_pin, ext_sel, wr, rd, evt, per_ev, addr, wdata} = '0;
    {error_cnt, compares, flush_cnt, restore_cnt, ovf_cnt, unf_cnt} = '0;
    last_ld = '0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    t_gated_entry();
    t_isr_return();
    t_periph_gate();
    t_stack();
    t_ext_edge();
    complete_run();
  end
endmodule : cie_irq_ctrl_tb
